// ==== spr_pkg.sv ====
// Shared constants, register map and carrier types for the storm policer and drop stage
package spr_pkg;

	// ==========================================================
	// Geometry
	localparam int unsigned NUM_PORTS = 4;
	localparam int unsigned PORT_W = 2;
	localparam int unsigned NUM_Q = 8;
	localparam int unsigned Q_W = 3;
	localparam int unsigned RED_Q = 6;
	localparam int unsigned ENTRIES = NUM_PORTS * NUM_Q;
	localparam int unsigned CNT_W = 16;
	localparam int unsigned NUM_CAST = 3;
	localparam int unsigned AVG_W = 10;
	localparam int unsigned AVG_FRAC = 3;

	// ==========================================================
	// Timing
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned REFILL_PERIOD_NS = 1000000;
	localparam int unsigned REFILL_CYCLES = REFILL_PERIOD_NS / CLK_PERIOD_NS;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_PORT_EN = 8'h04;
	localparam logic [7:0] OFS_RATE_UC = 8'h08;
	localparam logic [7:0] OFS_RATE_MC = 8'h0C;
	localparam logic [7:0] OFS_RATE_BC = 8'h10;
	localparam logic [7:0] OFS_RED_EN = 8'h14;
	localparam logic [7:0] OFS_RED_BASE = 8'h20;
	localparam logic [7:0] OFS_CNT_SEL = 8'h40;
	localparam logic [7:0] OFS_CNT_RX = 8'h44;
	localparam logic [7:0] OFS_CNT_TX = 8'h48;
	localparam logic [7:0] OFS_DROPS = 8'h4C;

	// ==========================================================
	// Field positions and limits
	localparam int unsigned CTRL_CLR_BIT = 0;
	localparam int unsigned RATE_UNIT_LSB = 20;
	localparam int unsigned SEL_Q_LSB = 4;
	localparam logic [19:0] RATE_RESET = 20'h001F4;
	localparam logic [19:0] RATE_FINE_MIN = 20'h00064;
	localparam logic [19:0] RATE_FINE_MAX = 20'hF4240;
	localparam logic [19:0] RATE_COARSE_MIN = 20'h00001;
	localparam logic [19:0] RATE_COARSE_MAX = 20'h03390;
	localparam logic [6:0] PCT_MAX = 7'h64;
	localparam logic [15:0] LFSR_SEED = 16'hACE1;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {UNIT_KBPS, UNIT_MBPS, UNIT_FPS, UNIT_KFPS} spr_unit_e;
	typedef enum logic [1:0] {CAST_UC, CAST_MC, CAST_BC} spr_cast_e;

	typedef struct packed {
		spr_unit_e unit;
		logic [19:0] rate;
	} spr_rate_s;

	typedef struct packed {
		logic [6:0] peak_drop_pct_level3;
		logic [6:0] peak_drop_pct_level2;
		logic [6:0] peak_drop_pct_level1;
		logic [6:0] min_pct;
	} spr_red_s;

	typedef struct packed {
		logic valid;
		logic [PORT_W-1:0] port;
		logic [Q_W-1:0] queue;
		spr_cast_e cast;
		logic flooded;
		logic [1:0] drop_level;
		logic [6:0] fill_pct;
		logic [13:0] len;
	} spr_desc_s;

	typedef struct packed {
		logic valid;
		logic drop;
		logic storm_hit;
		logic red_hit;
		logic [PORT_W-1:0] port;
		logic [Q_W-1:0] queue;
	} spr_dec_s;

endpackage : spr_pkg

// ==== spr_bucket.sv ====
// Token bucket for one storm policer class
`timescale 1ns/1ps

module spr_bucket (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Configuration and refill
	input spr_pkg::spr_rate_s cfg,
	input wire logic refill,
	// Frame check
	input wire logic [13:0] frame_len,
	input wire logic charge,
	output logic conform
);

	// ==========================================================
	// Credit and cost
	// Bit units count bits, frame units count thousandths of a frame
	localparam logic [27:0] MAX_COST = 28'h001FFF8;
	logic [27:0] level_ff;
	logic [27:0] nxt_level;
	logic [27:0] add;
	logic [27:0] cost;
	logic [27:0] cap;
	logic [28:0] sum;

	always_comb begin
		case (cfg.unit)
			spr_pkg::UNIT_MBPS, spr_pkg::UNIT_KFPS: add = 28'(28'(cfg.rate) * 28'd1000);
			default: add = 28'(cfg.rate);
		endcase
		if (cfg.unit == spr_pkg::UNIT_FPS || cfg.unit == spr_pkg::UNIT_KFPS) begin
			cost = 28'd1000;
		end else begin
			cost = {11'h000, frame_len, 3'b000};
		end
		cap = 28'(add + MAX_COST);
	end

	assign conform = level_ff >= cost;

	// Refill and charge in the same cycle are both honoured
	always_comb begin
		sum = {1'b0, level_ff} - ((charge && conform) ? {1'b0, cost} : 29'h0) + (refill ? {1'b0, add} : 29'h0);
		nxt_level = (sum > {1'b0, cap}) ? cap : sum[27:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_ff <= 28'h0;
		end else begin
			level_ff <= nxt_level;
		end
	end

endmodule : spr_bucket

// ==== spr_admit.sv ====
// Frame admission: storm policers, weighted random early drop, queue packet counters
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
// ==========================================================

module spr_admit #(
	parameter int unsigned REFILL_CYCLES = spr_pkg::REFILL_CYCLES
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Frame descriptors from the forwarding pipeline
	input spr_pkg::spr_desc_s desc,
	// Transmit completions from the egress queues
	input wire logic tx_done,
	input wire logic [1:0] tx_port,
	input wire logic [2:0] tx_queue,
	// Admission decisions
	output spr_pkg::spr_dec_s dec
);

	// ==========================================================
	// Register state
	logic pready_ff;
	logic pslverr_ff;
	logic [31:0] prdata_ff;
	logic clr_ff;
	logic [spr_pkg::NUM_PORTS-1:0] port_en_ff;
	spr_pkg::spr_rate_s [spr_pkg::NUM_CAST-1:0] rate_ff;
	logic [spr_pkg::RED_Q-1:0] red_en_ff;
	spr_pkg::spr_red_s [spr_pkg::RED_Q-1:0] red_ff;
	logic [4:0] sel_ff;
	logic [15:0] storm_drops_ff;
	logic [15:0] red_drops_ff;
	logic [spr_pkg::CNT_W-1:0] rx_cnt [spr_pkg::ENTRIES];
	logic [spr_pkg::CNT_W-1:0] tx_cnt [spr_pkg::ENTRIES];
	logic [spr_pkg::AVG_W-1:0] avg_ff [spr_pkg::ENTRIES];
	logic [15:0] lfsr_ff;
	logic [16:0] tick_ff;
	spr_pkg::spr_dec_s dec_ff;

	logic wr_en;
	logic red_sel;
	logic [2:0] red_idx;
	logic rd_hit;
	logic [31:0] rd_data;

	// ==========================================================
	// APB: one wait state so read data leaves a flip-flop
	assign wr_en = psel && penable && pready_ff && pwrite;
	assign red_idx = paddr[4:2];
	assign red_sel = (paddr[7:5] == spr_pkg::OFS_RED_BASE[7:5]) && (red_idx < 3'(spr_pkg::RED_Q)) && (paddr[1:0] == 2'b00);

	always_comb begin
		rd_hit = 1'b1;
		rd_data = 32'h0;
		if (red_sel) begin
			rd_data = {1'b0, red_ff[red_idx].peak_drop_pct_level3, 1'b0, red_ff[red_idx].peak_drop_pct_level2,
				1'b0, red_ff[red_idx].peak_drop_pct_level1, 1'b0, red_ff[red_idx].min_pct};
		end else begin
			case (paddr)
				spr_pkg::OFS_CTRL: rd_data = 32'h0;
				spr_pkg::OFS_PORT_EN: rd_data = 32'(port_en_ff);
				spr_pkg::OFS_RATE_UC: rd_data = 32'(rate_ff[0]);
				spr_pkg::OFS_RATE_MC: rd_data = 32'(rate_ff[1]);
				spr_pkg::OFS_RATE_BC: rd_data = 32'(rate_ff[2]);
				spr_pkg::OFS_RED_EN: rd_data = 32'(red_en_ff);
				spr_pkg::OFS_CNT_SEL: rd_data = {25'h0, sel_ff[2:0], 2'b00, sel_ff[4:3]};
				spr_pkg::OFS_CNT_RX: rd_data = 32'(rx_cnt[sel_ff]);
				spr_pkg::OFS_CNT_TX: rd_data = 32'(tx_cnt[sel_ff]);
				spr_pkg::OFS_DROPS: rd_data = {red_drops_ff, storm_drops_ff};
				default: rd_hit = 1'b0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0;
		end else begin
			pready_ff <= psel && penable && !pready_ff;
			pslverr_ff <= psel && penable && !pready_ff && !rd_hit;
			prdata_ff <= (psel && penable && !pready_ff && !pwrite) ? rd_data : 32'h0;
		end
	end

	// Out-of-range rates are pulled to the nearest legal value on write
	function automatic spr_pkg::spr_rate_s clamp_rate(input logic [31:0] w);
		spr_pkg::spr_rate_s r;
		logic [19:0] lo;
		logic [19:0] hi;
		r.unit = spr_pkg::spr_unit_e'(w[spr_pkg::RATE_UNIT_LSB+:2]);
		r.rate = w[19:0];
		lo = spr_pkg::RATE_FINE_MIN;
		hi = spr_pkg::RATE_FINE_MAX;
		if (r.unit == spr_pkg::UNIT_MBPS || r.unit == spr_pkg::UNIT_KFPS) begin
			lo = spr_pkg::RATE_COARSE_MIN;
			hi = spr_pkg::RATE_COARSE_MAX;
		end
		if (r.rate < lo) r.rate = lo;
		if (r.rate > hi) r.rate = hi;
		return r;
	endfunction : clamp_rate

	function automatic logic [6:0] clamp_pct(input logic [7:0] v);
		return (v > {1'b0, spr_pkg::PCT_MAX}) ? spr_pkg::PCT_MAX : v[6:0];
	endfunction : clamp_pct

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_en_ff <= '0;
			red_en_ff <= '0;
			sel_ff <= 5'h00;
			clr_ff <= 1'b0;
			for (int i = 0; i < spr_pkg::NUM_CAST; i++) begin
				rate_ff[i] <= '{unit: spr_pkg::UNIT_KBPS, rate: spr_pkg::RATE_RESET};
			end
			for (int i = 0; i < spr_pkg::RED_Q; i++) begin
				red_ff[i] <= '0;
			end
		end else begin
			clr_ff <= wr_en && (paddr == spr_pkg::OFS_CTRL) && pwdata[spr_pkg::CTRL_CLR_BIT];
			if (wr_en && paddr == spr_pkg::OFS_PORT_EN) port_en_ff <= pwdata[spr_pkg::NUM_PORTS-1:0];
			if (wr_en && paddr == spr_pkg::OFS_RATE_UC) rate_ff[0] <= clamp_rate(pwdata);
			if (wr_en && paddr == spr_pkg::OFS_RATE_MC) rate_ff[1] <= clamp_rate(pwdata);
			if (wr_en && paddr == spr_pkg::OFS_RATE_BC) rate_ff[2] <= clamp_rate(pwdata);
			if (wr_en && paddr == spr_pkg::OFS_RED_EN) red_en_ff <= pwdata[spr_pkg::RED_Q-1:0];
			if (wr_en && paddr == spr_pkg::OFS_CNT_SEL) sel_ff <= {pwdata[1:0], pwdata[spr_pkg::SEL_Q_LSB+:3]};
			if (wr_en && red_sel) begin
				red_ff[red_idx] <= '{peak_drop_pct_level3: clamp_pct(pwdata[31:24]),
					peak_drop_pct_level2: clamp_pct(pwdata[23:16]),
					peak_drop_pct_level1: clamp_pct(pwdata[15:8]),
					min_pct: clamp_pct(pwdata[7:0])};
			end
		end
	end

	// ==========================================================
	// Storm policers
	logic refill;
	logic policed;
	logic [spr_pkg::NUM_CAST-1:0] conform;
	logic storm_drop;

	assign refill = (tick_ff == 17'(REFILL_CYCLES - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_ff <= 17'h0;
		end else begin
			tick_ff <= refill ? 17'h0 : 17'(tick_ff + 17'h1);
		end
	end

	assign policed = desc.valid && desc.flooded && port_en_ff[desc.port] && (desc.cast != 2'd3);
	assign storm_drop = policed && !conform[desc.cast];

	for (genvar c = 0; c < spr_pkg::NUM_CAST; c++) begin : g_pol
		spr_bucket u_bucket (
			.pclk(pclk),
			.presetn(presetn),
			.cfg(rate_ff[c]),
			.refill(refill),
			.frame_len(desc.len),
			.charge(policed && desc.cast == spr_pkg::spr_cast_e'(c)),
			.conform(conform[c])
		);
	end

	// ==========================================================
	// Random early drop, configuration shared by all ports
	logic [4:0] idx;
	logic [2:0] rq;
	logic [9:0] avg8;
	logic [9:0] min8;
	logic [6:0] peak;
	logic red_ok;
	logic [31:0] lhs;
	logic [31:0] rhs;
	logic red_drop;
	logic admit;

	assign idx = {desc.port, desc.queue};
	assign rq = (desc.queue < 3'(spr_pkg::RED_Q)) ? desc.queue : 3'h0;
	assign avg8 = avg_ff[idx];
	assign min8 = {red_ff[rq].min_pct, 3'b000};

	always_comb begin
		case (desc.drop_level)
			2'd1: peak = red_ff[rq].peak_drop_pct_level1;
			2'd2: peak = red_ff[rq].peak_drop_pct_level2;
			2'd3: peak = red_ff[rq].peak_drop_pct_level3;
			default: peak = 7'h00;
		endcase
	end

	// Compare draw * span against peak * excess, avoiding a divider
	assign red_ok = desc.valid && (desc.queue < 3'(spr_pkg::RED_Q)) && red_en_ff[rq] && (avg8 > min8);
	assign lhs = 32'(lfsr_ff) * 32'd100 * 32'(spr_pkg::PCT_MAX - red_ff[rq].min_pct);
	assign rhs = (32'(peak) * 32'(avg8 - min8)) << 13;
	assign red_drop = red_ok && (lhs < rhs);
	assign admit = desc.valid && !storm_drop && !red_drop;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lfsr_ff <= spr_pkg::LFSR_SEED;
		end else begin
			lfsr_ff <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
		end
	end

	// Weight of one eighth per arrival keeps the average cheap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < spr_pkg::ENTRIES; i++) avg_ff[i] <= '0;
		end else if (desc.valid) begin
			avg_ff[idx] <= avg8 - (avg8 >> spr_pkg::AVG_FRAC) + {3'b000, desc.fill_pct};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dec_ff <= '0;
		end else begin
			dec_ff.valid <= desc.valid;
			dec_ff.drop <= desc.valid && !admit;
			dec_ff.storm_hit <= storm_drop;
			dec_ff.red_hit <= !storm_drop && red_drop;
			dec_ff.port <= desc.port;
			dec_ff.queue <= desc.queue;
		end
	end

	// ==========================================================
	// Queue packet counters, eight queues per port
	for (genvar e = 0; e < spr_pkg::ENTRIES; e++) begin : g_cnt
		logic rx_inc;
		logic tx_inc;
		assign rx_inc = admit && (idx == 5'(e));
		assign tx_inc = tx_done && ({tx_port, tx_queue} == 5'(e));
		// A count landing on the clear cycle survives as one
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				rx_cnt[e] <= '0;
				tx_cnt[e] <= '0;
			end else if (clr_ff) begin
				rx_cnt[e] <= 16'(rx_inc);
				tx_cnt[e] <= 16'(tx_inc);
			end else begin
				rx_cnt[e] <= rx_cnt[e] + 16'(rx_inc);
				tx_cnt[e] <= tx_cnt[e] + 16'(tx_inc);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			storm_drops_ff <= 16'h0;
			red_drops_ff <= 16'h0;
		end else begin
			storm_drops_ff <= (clr_ff ? 16'h0 : storm_drops_ff) + 16'(storm_drop);
			red_drops_ff <= (clr_ff ? 16'h0 : red_drops_ff) + 16'(!storm_drop && red_drop);
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign dec = dec_ff;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_KNOWN_BYPASS: assert property (desc.valid && !desc.flooded |=> !dec.storm_hit)
		else $error("known destination frame was storm dropped");
	AST_PORT_OFF: assert property (desc.valid && !port_en_ff[desc.port] |=> !dec.storm_hit)
		else $error("storm drop on disabled port");
	AST_EMPTY_DROP: assert property (policed && !conform[desc.cast] |=> dec.drop && dec.storm_hit)
		else $error("empty bucket did not drop");
	AST_RATE_RANGE: assert property ((rate_ff[0].unit inside {spr_pkg::UNIT_MBPS, spr_pkg::UNIT_KFPS})
		? (rate_ff[0].rate inside {[spr_pkg::RATE_COARSE_MIN:spr_pkg::RATE_COARSE_MAX]})
		: (rate_ff[0].rate inside {[spr_pkg::RATE_FINE_MIN:spr_pkg::RATE_FINE_MAX]}))
		else $error("unicast rate outside legal range");
	AST_HIGH_Q: assert property (desc.valid && desc.queue >= 3'(spr_pkg::RED_Q) |=> !dec.red_hit)
		else $error("random drop on queue 6 or 7");
	AST_RED_OFF: assert property (desc.valid && !red_en_ff[rq] |=> !dec.red_hit)
		else $error("random drop on disabled queue");
	AST_BELOW_MIN: assert property (desc.valid && avg8 <= min8 |=> !dec.red_hit)
		else $error("random drop below threshold");
	AST_LEVEL0: assert property (desc.valid && desc.drop_level == 2'd0 |=> !dec.red_hit)
		else $error("drop level zero frame randomly dropped");
	AST_CLEAR: assert property (clr_ff && !(admit && idx == 5'h00) |=> rx_cnt[0] == '0)
		else $error("counter not cleared");
	AST_DEC_TIMING: assert property (desc.valid |=> dec.valid && dec.port == $past(desc.port))
		else $error("decision missing one cycle after frame");

	COV_STORM: cover property (dec.valid && dec.storm_hit);
	COV_RED: cover property (dec.valid && dec.red_hit);
	COV_ADMIT: cover property (dec.valid && !dec.drop);
	COV_CLEAR: cover property (clr_ff);

endmodule : spr_admit

// ==== spr_fwd_model.sv ====
// Forwarding pipeline and egress queue model that feeds frames and completions
`timescale 1ns/1ps

module spr_fwd_model (
	// Clock
	input wire logic pclk,
	// Frame descriptors and completions
	output spr_pkg::spr_desc_s desc,
	output logic tx_done,
	output logic [1:0] tx_port,
	output logic [2:0] tx_queue,
	// Decisions
	input spr_pkg::spr_dec_s dec
);
	initial begin
		desc = '0;
		tx_done = 1'b0;
		tx_port = 2'h0;
		tx_queue = 3'h0;
	end

	// ==========================================================
	// One frame; the decision is taken exactly one cycle after it
	task automatic send(input spr_pkg::spr_desc_s d, output spr_pkg::spr_dec_s r);
		spr_pkg::spr_desc_s idle;
		// Released fields show the inverse so a stale value cannot pass
		idle = ~d;
		idle.valid = 1'b0;
		@(posedge pclk);
		desc <= d;
		@(posedge pclk);
		desc <= idle;
		@(posedge pclk);
		r = dec;
	endtask : send

	// ==========================================================
	// One transmitted packet
	task automatic transmit(input logic [1:0] p, input logic [2:0] q);
		@(posedge pclk);
		tx_done <= 1'b1;
		tx_port <= p;
		tx_queue <= q;
		@(posedge pclk);
		tx_done <= 1'b0;
		tx_port <= ~p;
		tx_queue <= ~q;
	endtask : transmit
endmodule : spr_fwd_model

// ==== spr_admit_tb_top.sv ====
// Self-checking testbench for the frame admission block
`timescale 1ns/1ps

module spr_admit_tb_top;
	// Short refill period keeps the run brief
	localparam int unsigned REFILL = 100;
	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	spr_pkg::spr_desc_s desc;
	spr_pkg::spr_dec_s dec;
	logic tx_done;
	logic [1:0] tx_port;
	logic [2:0] tx_queue;
	spr_pkg::spr_dec_s r;
	logic [31:0] rd;
	logic se;
	logic [19:0] v;
	logic [1:0] lv;
	logic [2:0] q;
	logic [1:0] p;
	logic [1:0] pq0;
	int n_errors;
	int samples_checked;
	int i;
	int j;
	int u;
	int cnt;
	int n;
	int nred;
	logic [2:0] qs [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6};

	spr_admit #(.REFILL_CYCLES(REFILL)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.desc(desc), .tx_done(tx_done), .tx_port(tx_port), .tx_queue(tx_queue), .dec(dec));
	spr_fwd_model u_fwd (.pclk(pclk), .desc(desc), .tx_done(tx_done), .tx_port(tx_port), .tx_queue(tx_queue),
		.dec(dec));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// ==========================================================
	// Reporting
	task automatic final_report;
		$display("Comparisons: %0d, mismatches: %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : final_report

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// ==========================================================
	// Expectations
	function automatic logic [19:0] clamp(input logic [1:0] un, input logic [19:0] val);
		logic fine;
		logic [19:0] lo;
		logic [19:0] hi;
		fine = (un == 2'h0) || (un == 2'h2);
		lo = fine ? 20'h00064 : 20'h00001;
		hi = fine ? 20'hF4240 : 20'h03390;
		return (val < lo) ? lo : ((val > hi) ? hi : val);
	endfunction : clamp

	function automatic logic red_exp(input logic [2:0] qq, input logic [1:0] l);
		return (l != 2'h0) && (qq == 3'h0 || (qq == 3'h3 && l == 2'h1));
	endfunction : red_exp

	// ==========================================================
	// APB master and frame helper
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (k == 20) begin
			n_errors++;
			final_report();
		end
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, $urandom);
		chk("reg_read", rd, exp);
	endtask : rchk

	task automatic frame(input logic [1:0] fp, input logic [2:0] fq, input logic [1:0] c, input logic fl,
		input logic [1:0] l, input logic [6:0] fill, input logic [13:0] ln);
		spr_pkg::spr_desc_s d;
		d.valid = 1'b1;
		d.port = fp;
		d.queue = fq;
		d.cast = spr_pkg::spr_cast_e'(c);
		d.flooded = fl;
		d.drop_level = l;
		d.fill_pct = fill;
		d.len = ln;
		u_fwd.send(d, r);
		chk("dec_route", 32'({r.valid, r.port, r.queue}), 32'({1'b1, fp, fq}));
	endtask : frame

	// ==========================================================
	// Main sequence
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		n_errors = 0;
		samples_checked = 0;
		nred = 0;
		presetn = 1'b0;
		void'($urandom(32'h336760a1));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		for (i = 0; i < 3; i++) rchk(8'(8 + 4 * i), 32'h000001F4);
		rchk(8'h04, 32'h0);
		rchk(8'h14, 32'h0);
		apb(1'b0, 8'h18, 32'h0);
		chk("unmapped", {se, rd[30:0]}, 32'h80000000);
		for (u = 0; u < 4; u++) begin
			for (j = 0; j < 3; j++) begin
				v = (j == 0) ? 20'h0 : ((j == 1) ? 20'hFFFFF : 20'($urandom));
				wr(8'h08, {10'h0, 2'(u), v});
				rchk(8'h08, {10'h0, 2'(u), clamp(2'(u), v)});
			end
		end
		// Storm policing: bc bucket starves on a maximal frame, uc gains a frame per refill
		wr(8'h04, 32'h1);
		wr(8'h10, 32'h00000064);
		wr(8'h08, 32'h002003E8);
		repeat (REFILL + 4) @(posedge pclk);
		frame(2'h0, 3'h7, 2'h0, 1'b1, 2'h0, 7'h0, 14'h0040);
		chk("storm_uc", 32'(r.drop), 32'h0);
		// Multicast bucket holds at least two refills at 500 kbps: a short frame fits, a maximal one not
		frame(2'h0, 3'h7, 2'h1, 1'b1, 2'h0, 7'h0, 14'h0040);
		chk("storm_mc", 32'({r.drop, r.storm_hit}), 32'h0);
		frame(2'h0, 3'h7, 2'h1, 1'b1, 2'h0, 7'h0, 14'h3FFF);
		chk("storm_mc_big", 32'({r.drop, r.storm_hit}), 32'h3);
		frame(2'h0, 3'h7, 2'h2, 1'b1, 2'h0, 7'h0, 14'h3FFF);
		chk("storm_bc", 32'({r.drop, r.storm_hit}), 32'h3);
		frame(2'h0, 3'h7, 2'h2, 1'b0, 2'h0, 7'h0, 14'h3FFF);
		chk("known_dst", 32'(r.drop), 32'h0);
		frame(2'h1, 3'h7, 2'h2, 1'b1, 2'h0, 7'h0, 14'h3FFF);
		chk("port_off", 32'(r.drop), 32'h0);
		frame(2'h0, 3'h7, 2'h3, 1'b1, 2'h0, 7'h0, 14'h3FFF);
		chk("cast_none", 32'(r.drop), 32'h0);
		// Random early drop at full average fill; queue 1 left disabled
		wr(8'h14, 32'h0000003D);
		wr(8'h20, 32'h64646400);
		wr(8'h24, 32'h64646400);
		wr(8'h28, 32'h64646464);
		wr(8'h2C, 32'h00006400);
		wr(8'h34, 32'h64646400);
		for (i = 0; i < 5; i++) begin
			q = qs[i];
			p = 2'($urandom_range(0, 3));
			if (i == 0) pq0 = p;
			repeat (80) begin
				frame(p, q, 2'h0, 1'b0, 2'h0, 7'h64, 14'h0040);
				chk("level0", 32'(r.drop), 32'h0);
			end
			repeat (8) begin
				lv = 2'($urandom_range(1, 3));
				frame(p, q, 2'h0, 1'b0, lv, 7'h64, 14'h0040);
				chk("red_full", 32'({r.drop, r.red_hit}), {30'h0, {2{red_exp(q, lv)}}});
				nred += int'(red_exp(q, lv));
			end
		end
		// Half average fill gives about half drops
		repeat (80) frame(2'h1, 3'h5, 2'h0, 1'b0, 2'h0, 7'h32, 14'h0040);
		cnt = 0;
		repeat (64) begin
			frame(2'h1, 3'h5, 2'h0, 1'b0, 2'($urandom_range(1, 3)), 7'h32, 14'h0040);
			cnt += int'(r.drop === 1'b1);
		end
		chk("red_half", 32'(cnt >= 16 && cnt <= 48), 32'h1);
		// Counters per queue, then one clear for all ports
		n = $urandom_range(1, 10);
		repeat (n) frame(2'h3, 3'h7, 2'h0, 1'b0, 2'h0, 7'h0, 14'h0040);
		repeat (n + 2) u_fwd.transmit(2'h3, 3'h7);
		u_fwd.transmit(2'h3, 3'h6);
		wr(8'h40, 32'h00000073);
		rchk(8'h44, 32'(n));
		rchk(8'h48, 32'(n + 2));
		rchk(8'h4C, {16'(cnt + nred), 16'h0002});
		wr(8'h00, 32'h1);
		rchk(8'h44, 32'h0);
		rchk(8'h4C, 32'h0);
		rchk(8'h48, 32'h0);
		wr(8'h40, 32'(pq0));
		rchk(8'h44, 32'h0);
		final_report();
	end
endmodule : spr_admit_tb_top
